// ===== lrxop_pkg.sv
// constants and types shared by the receive output pin block
// How it works
// RL1 - build-out select high disables build-out (partial shaping), low enables it
// RL2 - build-out select acts only in hardware mode at DS3 or STS-1 rate
// RL3 - hardware mode: receiver powered and enabled while receiver-on pin is high
// RL4 - host mode: receiver-on pin becomes serial configuration data input
// RL5 - hardware mode: equalizer follows equalizer-enable pin
// RL6 - host mode: equalizer-enable pin is ignored entirely
// RL7 - recovered clock driven out; data changes on its rising edge by default
// RL8 - hardware mode: invert pin high inverts clock, data on falling edge
// RL9 - host mode: inversion bit set moves data updates to falling edge
// RL10 - host mode: invert pin becomes serial interface chip select
// RL11 - positive data output pulses high per detected positive line pulse
// RL12 - dual rail: negative data output pulses per detected negative pulse
// RL13 - single rail: negative pin pulses high on code violation, else low
// RL14 - each pulse lasts one recovered period, changes only on selected edge
package lrxop_pkg;

  // rate selection
  typedef enum logic [1:0]
  {
    LRXOP_RATE_E3,
    LRXOP_RATE_DS3,
    LRXOP_RATE_STS1,
    LRXOP_RATE_RSVD
  } lrxop_rate_t;

  // ----------------------------------------------------------------
  // buffered word layout
  // ----------------------------------------------------------------
  localparam int FIFO_WIDTH = 3;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW    = 2;
  localparam int POS_BIT    = 0;
  localparam int NEG_BIT    = 1;
  localparam int CV_BIT     = 2;

  // ----------------------------------------------------------------
  // synchroniser vector layout
  // ----------------------------------------------------------------
  localparam int SYNC_W       = 11;
  localparam int S_RCLK       = 0;
  localparam int S_POS        = 1;
  localparam int S_NEG        = 2;
  localparam int S_CV         = 3;
  localparam int S_LBO        = 4;
  localparam int S_RPWR       = 5;
  localparam int S_EQ         = 6;
  localparam int S_INV        = 7;
  localparam int S_HW         = 8;
  localparam int S_RATE_LO    = 9;
  localparam int S_RATE_HI    = 10;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [SYNC_W-1:0]     SYNC_RST = 11'h000;
  localparam logic [FIFO_WIDTH-1:0] WORD_RST = 3'h0;
  localparam logic                  BIT_RST  = 1'b0;

endpackage

// ===== lrxop_fifo_if.sv
// carrier between the capture logic and the output buffer
`timescale 1ns/1ps
`default_nettype none
interface lrxop_fifo_if;
  logic                            in_valid;
  logic                            in_ready;
  logic [lrxop_pkg::FIFO_WIDTH-1:0] in_data;
  logic                            out_valid;
  logic                            out_ready;
  logic [lrxop_pkg::FIFO_WIDTH-1:0] out_data;

  modport src
  (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );

  modport buf_side
  (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );
endinterface
`default_nettype wire

// ===== lrxop_fifo.sv
// small flip-flop fifo for recovered pulse words
`timescale 1ns/1ps
`default_nettype none
module lrxop_fifo #(
  parameter int WIDTH = lrxop_pkg::FIFO_WIDTH,
  parameter int DEPTH = lrxop_pkg::FIFO_DEPTH,
  parameter int AW    = lrxop_pkg::FIFO_AW
)
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  lrxop_fifo_if.buf_side f
);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              do_push;
  wire              do_pop;

  assign f.in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_r != '0);
  assign f.out_data  = mem_r[rd_r];
  assign do_push     = f.in_valid & f.in_ready;
  assign do_pop      = f.out_valid & f.out_ready;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (do_push)
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      if (do_pop)
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // storage needs no reset; count guards reads
  always_ff @(posedge clk)
  begin
    if (do_push)
      mem_r[wr_r] <= f.in_data;
  end

endmodule
`default_nettype wire

// ===== lrxop_top.sv
// receive output timing and hardware strap decode
`timescale 1ns/1ps
`default_nettype none
module lrxop_top
(
  input  wire logic clk,
  input  wire logic sys_rst,
  // recovered link from the clock and data recovery stage
  input  wire logic rec_clk_in,
  input  wire logic line_pos_det,
  input  wire logic line_neg_det,
  input  wire logic line_cv_det,
  // mode straps
  input  wire logic hw_mode_sel,
  input  wire logic [1:0] rate_sel,
  input  wire logic single_rail_sel,
  // shared control pins
  input  wire logic build_out_disable_sel,
  input  wire logic receiver_power_on,
  input  wire logic rx_equalizer_enable,
  input  wire logic recovered_edge_invert,
  // host register bit, same clock domain
  input  wire logic host_rx_clk_inv,
  // decoded controls
  output logic      build_out_disabled,
  output logic      receiver_enabled,
  output logic      equalizer_enabled,
  output logic      serial_cfg_data_in,
  output logic      serial_cfg_select,
  // terminal side
  output logic      recovered_clock_out,
  output logic      rx_positive_pulse_out,
  output logic      rx_negative_pulse_out,
  output logic      capture_overrun
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire  [lrxop_pkg::SYNC_W-1:0] raw_in;
  logic [lrxop_pkg::SYNC_W-1:0] meta_r;
  logic [lrxop_pkg::SYNC_W-1:0] sync_r;

  assign raw_in = {rate_sel,
                   hw_mode_sel,
                   recovered_edge_invert,
                   rx_equalizer_enable,
                   receiver_power_on,
                   build_out_disable_sel,
                   line_cv_det,
                   line_neg_det,
                   line_pos_det,
                   rec_clk_in};

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      meta_r <= lrxop_pkg::SYNC_RST;
      sync_r <= lrxop_pkg::SYNC_RST;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  function automatic logic rise(input logic prev, input logic cur);
    rise = ~prev & cur;
  endfunction

  function automatic logic fall(input logic prev, input logic cur);
    fall = prev & ~cur;
  endfunction

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  lrxop_pkg::lrxop_rate_t rate;
  wire  hw_mode;
  wire  host_mode;
  wire  rate_lbo_ok;
  wire  rx_on;
  wire  inv_sel;
  logic lbo_dis_nxt;
  logic rx_on_nxt;
  logic eq_nxt;
  logic ser_din_nxt;
  logic cs_nxt;

  assign rate      = lrxop_pkg::lrxop_rate_t'(
                       {sync_r[lrxop_pkg::S_RATE_HI],
                        sync_r[lrxop_pkg::S_RATE_LO]});
  assign hw_mode   = sync_r[lrxop_pkg::S_HW];
  assign host_mode = ~hw_mode;
  assign rate_lbo_ok = (rate == lrxop_pkg::LRXOP_RATE_DS3) |
                       (rate == lrxop_pkg::LRXOP_RATE_STS1);

  always_comb
  begin
    lbo_dis_nxt = 1'b0;
    rx_on_nxt   = 1'b0;
    eq_nxt      = 1'b0;
    ser_din_nxt = 1'b0;
    cs_nxt      = 1'b0;
    case (hw_mode)
      1'b1:
      begin
        // high disables build-out, low keeps full shaping [RL1]
        lbo_dis_nxt = sync_r[lrxop_pkg::S_LBO] & rate_lbo_ok; // [RL2]
        rx_on_nxt   = sync_r[lrxop_pkg::S_RPWR]; // [RL3]
        eq_nxt      = sync_r[lrxop_pkg::S_EQ]; // [RL5]
      end
      1'b0:
      begin
        // host owns the receiver; pins go to the serial port
        rx_on_nxt   = 1'b1;
        ser_din_nxt = sync_r[lrxop_pkg::S_RPWR]; // [RL4]
        cs_nxt    = sync_r[lrxop_pkg::S_INV]; // [RL10]
        eq_nxt    = 1'b0; // [RL6]
      end
      default:
      begin
        rx_on_nxt = 1'b0;
      end
    endcase
  end

  // inversion source follows the mode [RL8] [RL9]
  assign inv_sel = host_mode ? host_rx_clk_inv : sync_r[lrxop_pkg::S_INV];

  logic lbo_dis_r;
  logic rx_on_r;
  logic eq_r;
  logic ser_din_r;
  logic cs_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lbo_dis_r <= lrxop_pkg::BIT_RST;
      rx_on_r   <= lrxop_pkg::BIT_RST;
      eq_r      <= lrxop_pkg::BIT_RST;
      ser_din_r <= lrxop_pkg::BIT_RST;
      cs_r      <= lrxop_pkg::BIT_RST;
    end
    else
    begin
      lbo_dis_r <= lbo_dis_nxt;
      rx_on_r   <= rx_on_nxt;
      eq_r      <= eq_nxt;
      ser_din_r <= ser_din_nxt;
      cs_r      <= cs_nxt;
    end
  end

  assign rx_on              = rx_on_r;
  assign build_out_disabled = lbo_dis_r;
  assign receiver_enabled   = rx_on_r;
  assign equalizer_enabled  = eq_r;
  assign serial_cfg_data_in = ser_din_r;
  assign serial_cfg_select  = cs_r;

  // ----------------------------------------------------------------
  // capture on recovered clock rising edge
  // ----------------------------------------------------------------
  lrxop_fifo_if fq ();

  logic                             rclk_d_r;
  logic                             pend_valid_r;
  logic [lrxop_pkg::FIFO_WIDTH-1:0] pend_data_r;
  logic                             ovr_r;
  wire                              in_edge;
  wire                              pushed;
  wire  [lrxop_pkg::FIFO_WIDTH-1:0] cap_word;

  assign in_edge  = rise(rclk_d_r, sync_r[lrxop_pkg::S_RCLK]) & rx_on;
  assign pushed   = pend_valid_r & fq.in_ready;
  assign cap_word = {sync_r[lrxop_pkg::S_CV],
                     sync_r[lrxop_pkg::S_NEG],
                     sync_r[lrxop_pkg::S_POS]};

  assign fq.in_valid = pend_valid_r;
  assign fq.in_data  = pend_data_r;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rclk_d_r     <= lrxop_pkg::BIT_RST;
      pend_valid_r <= lrxop_pkg::BIT_RST;
      pend_data_r  <= lrxop_pkg::WORD_RST;
      ovr_r        <= lrxop_pkg::BIT_RST;
    end
    else
    begin
      rclk_d_r <= sync_r[lrxop_pkg::S_RCLK];
      // a new word over an unaccepted one is an overrun
      ovr_r    <= in_edge & pend_valid_r & ~fq.in_ready;
      if (in_edge)
      begin
        pend_valid_r <= 1'b1;
        pend_data_r  <= cap_word;
      end
      else if (pushed | ~rx_on)
      begin
        pend_valid_r <= 1'b0;
      end
    end
  end

  assign capture_overrun = ovr_r;

  lrxop_fifo u_fifo
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .f       (fq.buf_side)
  );

  // ----------------------------------------------------------------
  // output clock and data update
  // ----------------------------------------------------------------
  logic clk_out_r;
  logic clk_out_d_r;
  logic pos_r;
  logic neg_r;
  logic pos_nxt;
  logic neg_nxt;
  wire  out_upd;

  // data moves on the selected edge of the driven clock [RL7] [RL14]
  assign out_upd = inv_sel ? fall(clk_out_d_r, clk_out_r)
                           : rise(clk_out_d_r, clk_out_r);

  // drain on each update; flush while the receiver is off
  assign fq.out_ready = out_upd | ~rx_on;

  always_comb
  begin
    pos_nxt = pos_r;
    neg_nxt = neg_r;
    if (~rx_on)
    begin
      pos_nxt = 1'b0;
      neg_nxt = 1'b0;
    end
    else if (out_upd)
    begin
      pos_nxt = fq.out_valid & fq.out_data[lrxop_pkg::POS_BIT]; // [RL11]
      neg_nxt = fq.out_valid &
                (single_rail_sel ? fq.out_data[lrxop_pkg::CV_BIT]   // [RL13]
                                 : fq.out_data[lrxop_pkg::NEG_BIT]); // [RL12]
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      clk_out_r   <= lrxop_pkg::BIT_RST;
      clk_out_d_r <= lrxop_pkg::BIT_RST;
      pos_r       <= lrxop_pkg::BIT_RST;
      neg_r       <= lrxop_pkg::BIT_RST;
    end
    else
    begin
      // recovered clock out, inverted on request [RL7] [RL8]
      clk_out_r   <= rx_on & (sync_r[lrxop_pkg::S_RCLK] ^ inv_sel);
      clk_out_d_r <= clk_out_r;
      pos_r       <= pos_nxt; // [RL14]
      neg_r       <= neg_nxt;
    end
  end

  assign recovered_clock_out   = clk_out_r;
  assign rx_positive_pulse_out = pos_r;
  assign rx_negative_pulse_out = neg_r;

endmodule
`default_nettype wire

// ===== lrxop_top_end.sv
// end marker module not used
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ===== lrxop_checker.sv
// concurrent checks on the receive output pin block ports
`timescale 1ns/1ps
`default_nettype none
module lrxop_checker
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       rec_clk_in,
  input wire logic       hw_mode_sel,
  input wire logic [1:0] rate_sel,
  input wire logic       build_out_disable_sel,
  input wire logic       receiver_power_on,
  input wire logic       rx_equalizer_enable,
  input wire logic       recovered_edge_invert,
  input wire logic       build_out_disabled,
  input wire logic       receiver_enabled,
  input wire logic       equalizer_enabled,
  input wire logic       serial_cfg_data_in,
  input wire logic       serial_cfg_select,
  input wire logic       recovered_clock_out,
  input wire logic       rx_positive_pulse_out,
  input wire logic       rx_negative_pulse_out
);
  logic [2:0] up_r;
  logic       ok;
  logic       rate_ok;

  // settle window after reset, covers the sync depth
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end
  assign ok      = (up_r == 3'h7);
  assign rate_ok = (rate_sel == 2'h1) || (rate_sel == 2'h2);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_bod;
    ok |-> build_out_disabled ==
      $past(build_out_disable_sel & hw_mode_sel & rate_ok, 3);
  endproperty
  a_bod: assert property (p_bod)
    else $error("build-out decode wrong");
  property p_rxen;
    ok |-> receiver_enabled == $past(!hw_mode_sel | receiver_power_on, 3);
  endproperty
  a_rxen: assert property (p_rxen)
    else $error("receiver enable wrong");
  property p_ser_din;
    ok |-> serial_cfg_data_in == $past(!hw_mode_sel & receiver_power_on, 3);
  endproperty
  a_ser_din: assert property (p_ser_din)
    else $error("serial data routing wrong");
  property p_eq;
    ok |-> equalizer_enabled == $past(hw_mode_sel & rx_equalizer_enable, 3);
  endproperty
  a_eq: assert property (p_eq)
    else $error("equalizer enable wrong");
  property p_cs;
    ok |-> serial_cfg_select ==
      $past(!hw_mode_sel & recovered_edge_invert, 3);
  endproperty
  a_cs: assert property (p_cs)
    else $error("chip select routing wrong");
  property p_clk;
    ok && $past(hw_mode_sel, 3) && $past(hw_mode_sel, 4) &&
      receiver_enabled && $past(receiver_enabled) |->
      recovered_clock_out == $past(rec_clk_in ^ recovered_edge_invert, 3);
  endproperty
  a_clk: assert property (p_clk)
    else $error("recovered clock output wrong");
  property p_off;
    !receiver_enabled && !$past(receiver_enabled) |-> !recovered_clock_out
      && !rx_positive_pulse_out && !rx_negative_pulse_out;
  endproperty
  a_off: assert property (p_off)
    else $error("outputs active with receiver off");
  property p_chg;
    ok && $changed(rx_positive_pulse_out) && receiver_enabled &&
      $past(receiver_enabled, 2) |->
      $past(recovered_clock_out, 1) != $past(recovered_clock_out, 2);
  endproperty
  a_chg: assert property (p_chg)
    else $error("data changed away from a clock edge");

  c_pos: cover property (rx_positive_pulse_out);
  c_inv: cover property (recovered_edge_invert && rx_positive_pulse_out);
  c_bod: cover property (build_out_disabled);
endmodule

bind lrxop_top lrxop_checker chk_u
(
  .clk(clk), .sys_rst(sys_rst), .rec_clk_in(rec_clk_in),
  .hw_mode_sel(hw_mode_sel), .rate_sel(rate_sel),
  .build_out_disable_sel(build_out_disable_sel),
  .receiver_power_on(receiver_power_on),
  .rx_equalizer_enable(rx_equalizer_enable),
  .recovered_edge_invert(recovered_edge_invert),
  .build_out_disabled(build_out_disabled),
  .receiver_enabled(receiver_enabled),
  .equalizer_enabled(equalizer_enabled),
  .serial_cfg_data_in(serial_cfg_data_in),
  .serial_cfg_select(serial_cfg_select),
  .recovered_clock_out(recovered_clock_out),
  .rx_positive_pulse_out(rx_positive_pulse_out),
  .rx_negative_pulse_out(rx_negative_pulse_out)
);
`default_nettype wire

// ===== lrxop_far_end.sv
// terminal equipment model sampling the recovered data outputs
`timescale 1ns/1ps
`default_nettype none
module lrxop_far_end
(
  input  wire logic rclk,
  input  wire logic inv,
  input  wire logic pos,
  input  wire logic neg,
  input  wire logic clr,
  output var  int   pos_cnt,
  output var  int   neg_cnt,
  output var  int   smp_cnt
);
  // samples on the edge opposite the update edge
  always @(rclk or posedge clr)
  begin
    if (clr)
    begin
      pos_cnt = 0;
      neg_cnt = 0;
      smp_cnt = 0;
    end
    else if (rclk === inv)
    begin
      smp_cnt++;
      pos_cnt += int'(pos === 1'b1);
      neg_cnt += int'(neg === 1'b1);
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the receive output pin block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  logic       clk, sys_rst, rec_clk_in, hw_mode_sel, single_rail_sel;
  logic       line_pos_det, line_neg_det, line_cv_det, host_rx_clk_inv;
  logic       bod_pin, pwr_pin, eq_pin, inv_pin, inv_eff, clr, ovr;
  logic [1:0] rate_sel;
  logic       bod, rxen, eqen, ser_din, cs, rco, pos_o, neg_o;
  logic [7:0] all_out;
  int         miscompares, tests_run, pos_cnt, neg_cnt, smp_cnt, ovr_cnt;
  logic [2:0] seq [8] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h0, 3'h6, 3'h1, 3'h1};

  assign inv_eff = hw_mode_sel ? inv_pin : host_rx_clk_inv;
  assign all_out = {bod, rxen, eqen, ser_din, cs, rco, pos_o, neg_o};

  lrxop_top dut_u
  (
    .clk(clk), .sys_rst(sys_rst), .rec_clk_in(rec_clk_in),
    .line_pos_det(line_pos_det), .line_neg_det(line_neg_det),
    .line_cv_det(line_cv_det), .hw_mode_sel(hw_mode_sel),
    .rate_sel(rate_sel), .single_rail_sel(single_rail_sel),
    .build_out_disable_sel(bod_pin), .receiver_power_on(pwr_pin),
    .rx_equalizer_enable(eq_pin), .recovered_edge_invert(inv_pin),
    .host_rx_clk_inv(host_rx_clk_inv), .build_out_disabled(bod),
    .receiver_enabled(rxen), .equalizer_enabled(eqen),
    .serial_cfg_data_in(ser_din), .serial_cfg_select(cs),
    .recovered_clock_out(rco), .rx_positive_pulse_out(pos_o),
    .rx_negative_pulse_out(neg_o), .capture_overrun(ovr)
  );
  lrxop_far_end far_u
  (
    .rclk(rco), .inv(inv_eff), .pos(pos_o), .neg(neg_o), .clr(clr),
    .pos_cnt(pos_cnt), .neg_cnt(neg_cnt), .smp_cnt(smp_cnt)
  );

  // lost words seen on the overrun pulse
  always @(posedge clk)
    if (ovr === 1'b1)
      ovr_cnt++;

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task report_and_stop;
    $display("miscompares %0d tests_run %0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one recovered period of 8 clocks; data held across the rising edge
  task send(input logic [2:0] w);
    {line_cv_det, line_neg_det, line_pos_det} = w;
    step(4);
    rec_clk_in = 1'b1;
    step(4);
    rec_clk_in = 1'b0;
  endtask

  task t_straps;
    logic h;
    logic p;
    logic r;
    for (int i = 0; i < 32; i++)
    begin
      {pwr_pin, bod_pin, rate_sel, hw_mode_sel} = 5'(i);
      {eq_pin, inv_pin} = {2{pwr_pin}};
      h = hw_mode_sel;
      p = pwr_pin;
      r = (rate_sel == 2'h1) || (rate_sel == 2'h2);
      step(5);
      `CHK(bod, bod_pin & h & r)
      `CHK(rxen, !h | p)
      `CHK(ser_din, !h & p)
      `CHK(eqen, h & p)
      `CHK(cs, !h & p)
    end
  endtask

  // frame of eight words, then the link clock stands still
  task t_rx(input logic h, v, sr, on, input int ep, en, es);
    hw_mode_sel = h;
    inv_pin = h & v;
    host_rx_clk_inv = v;
    single_rail_sel = sr;
    pwr_pin = on;
    rate_sel = 2'h1;
    step(6);
    clr = 1'b1;
    step(1);
    clr = 1'b0;
    for (int i = 0; i < 8; i++)
      send(seq[i]);
    // a word leaves one period late; an idle period drains the last
    send(3'h0);
    {line_cv_det, line_neg_det, line_pos_det} = 3'h6;
    step(8);
    `CHK(pos_cnt, ep)
    `CHK(neg_cnt, en)
    `CHK(smp_cnt, es)
    `CHK(pos_o, on | !h)
    `CHK(ovr_cnt, 0)
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    report_and_stop;
  end

  initial
  begin
    {rec_clk_in, hw_mode_sel, single_rail_sel, line_pos_det} = 4'h0;
    {line_neg_det, line_cv_det, host_rx_clk_inv, clr} = 4'h0;
    {bod_pin, pwr_pin, eq_pin, inv_pin, rate_sel} = 6'h00;
    sys_rst = 1'b1;
    step(6);
    `CHK(all_out, 8'h00)
    sys_rst = 1'b0;
    t_straps;
    t_rx(1'b1, 1'b0, 1'b0, 1'b1, 4, 2, 9);
    t_rx(1'b1, 1'b1, 1'b1, 1'b1, 4, 3, 9);
    t_rx(1'b0, 1'b1, 1'b0, 1'b0, 4, 2, 9);
    t_rx(1'b1, 1'b0, 1'b0, 1'b0, 0, 0, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
